// ==== pkg/gbd_pkg.sv ====
// Constants, state carrier and bus carrier for the instrument bus decoder.
// Assumes a single 100 MHz system clock and low-true bus pins outside.
//
// Functional notes
// - A uniline command is its own bus line pulled low, read as true.
// - Bytes with attention true are interface commands, never instrument data.
// - Bytes with attention false go to the instrument parser as data.
// - Only controller drives ATN, IFC, REN; device drives service request.
// - Remote enable true moves device to remote; panel may lock by config.
// - Source marks last byte of a message with end-or-identify.
// - Interface clear puts device in talker idle and listener idle.
// - Service request held asserted from request until serviced.
// - Universal commands acted on without addressing, at byte acceptance.
// - Local lockout command sets lockout, disabling front panel controls.
// - Universal device clear returns device to power-up defaults.
// - Serial poll enable places device in serial poll mode.
// - Serial poll disable takes device out of serial poll mode.
// - Addressed commands obeyed only when already listen-addressed, GET also by config.
// - Selective device clear acts like universal clear, listener only.
// - Go-to-local returns addressed device to local, optionally unlocks.
// - Group trigger starts an action; may be accepted unaddressed.
// - Listen address is primary address ORed with hex 20.
// - Talk address is primary address ORed with hex 40.
// - Secondary command group bytes never change addressing state.
// - Unlisten drops device into listener idle.
// - Untalk drops device into talker idle.
// - Primary address is 0 to 30, from switches or panel.
// - Every bus line is low-true.
// - Bytes move by interlocked DAV, NRFD, NDAC handshake.

package gbd_pkg;

  // ---------------------------------------------------------------
  // Multiline command codes, seven bits, DIO8 ignored
  // ---------------------------------------------------------------
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  // ---------------------------------------------------------------
  // Address derivation and groups
  // ---------------------------------------------------------------
  localparam logic [6:0] LISTEN_OR  = 7'h20;
  localparam logic [6:0] TALK_OR    = 7'h40;
  localparam logic [6:0] SEC_BASE   = 7'h60;
  localparam logic [1:0] GRP_TALK   = 2'h2;

  // Acceptor handshake states
  typedef enum logic [0:0] {
    HS_READY = 1'b0,
    HS_DONE  = 1'b1
  } gbd_hs_e;

  // Bus lines after low-true decode, high means true
  typedef struct packed {
    logic       atn;
    logic       ifc;
    logic       ren;
    logic       eoi;
    logic       dav;
    logic [7:0] dio;
  } gbd_bus_s;

  // Whole state of the decoder
  typedef struct packed {
    gbd_hs_e    hs;
    logic       listen;
    logic       talk;
    logic       remote;
    logic       lockout;
    logic       spoll;
    logic       srq;
    logic       ren_prev;
    logic [7:0] data;
    logic       data_eoi;
    logic       data_vld;
    logic       clr;
    logic       trig;
  } gbd_state_s;

  localparam gbd_state_s ST_RESET = '0;

endpackage

// ==== src/gbd_decoder.sv ====
// Device-side instrument bus command decoder with acceptor handshake.
// Assumes bus pins already synchronous to CLK_SYS_I; open-drain wiring
// of NRFD, NDAC and SRQ is resolved outside from the enables.
`timescale 1ns/1ps

module gbd_decoder
(
  // Clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  // Low-true bus management and handshake inputs
  input  wire logic       ATN_N_I,
  input  wire logic       IFC_N_I,
  input  wire logic       REN_N_I,
  input  wire logic       EOI_N_I,
  input  wire logic       DAV_N_I,
  input  wire logic [7:0] DIO_N_I,
  // Open-drain acceptor lines
  input  wire logic       NRFD_N_I,
  output logic            NRFD_N_O,
  output logic            NRFD_N_OE_O,
  input  wire logic       NDAC_N_I,
  output logic            NDAC_N_O,
  output logic            NDAC_N_OE_O,
  // Open-drain service request line
  input  wire logic       SRQ_N_I,
  output logic            SRQ_N_O,
  output logic            SRQ_N_OE_O,
  // Configuration
  input  wire logic [4:0] ADDR_I,
  input  wire logic       REN_LOCKS_PANEL_I,
  input  wire logic       GTL_UNLOCK_I,
  input  wire logic       GET_ANY_I,
  // Instrument side
  input  wire logic       SERVICE_REQ_I,
  input  wire logic       LOCAL_BTN_I,
  input  wire logic       DD_READY_I,
  output logic [7:0]      DD_DATA_O,
  output logic            DD_EOI_O,
  output logic            DD_VALID_O,
  output logic            DEV_CLEAR_O,
  output logic            TRIGGER_O,
  // Interface status
  output logic            LISTEN_O,
  output logic            TALK_O,
  output logic            REMOTE_O,
  output logic            LOCKOUT_O,
  output logic            SPOLL_O,
  output logic            PANEL_LOCK_O
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  gbd_pkg::gbd_bus_s   bus;
  gbd_pkg::gbd_state_s st_q;
  gbd_pkg::gbd_state_s st_d;
  logic [6:0]          code;
  logic [6:0]          my_lad;
  logic [6:0]          my_tad;
  logic                participate;
  logic                ready;
  logic                capture;
  logic                unused_rb;

  // Low level on a line means true
  always_comb
  begin
    bus.atn = ~ATN_N_I;
    bus.ifc = ~IFC_N_I;
    bus.ren = ~REN_N_I;
    bus.eoi = ~EOI_N_I;
    bus.dav = ~DAV_N_I;
    bus.dio = ~DIO_N_I;
  end

  // Own addresses from the switch value
  assign code   = bus.dio[6:0];
  assign my_lad = gbd_pkg::LISTEN_OR | {2'b00, ADDR_I};
  assign my_tad = gbd_pkg::TALK_OR | {2'b00, ADDR_I};

  // Wire read-backs are not needed; the enables fully describe us
  assign unused_rb = NRFD_N_I ^ NDAC_N_I ^ SRQ_N_I;

  // ---------------------------------------------------------------
  // Acceptor handshake
  // ---------------------------------------------------------------

  // Take part on every command byte, and on data only as a listener
  assign participate = bus.atn | st_q.listen;
  // Data bytes wait for the parser; commands are never held off
  assign ready       = bus.atn | DD_READY_I;
  assign capture     = (st_q.hs == gbd_pkg::HS_READY) & participate &
                       ready & bus.dav;

  // NRFD released in HS_READY when ready or not taking part; NDAC released once byte taken
  always_comb
  begin
    NRFD_N_O    = 1'b0;
    NDAC_N_O    = 1'b0;
    NRFD_N_OE_O = (st_q.hs == gbd_pkg::HS_DONE) |
                  (participate & ~ready);
    NDAC_N_OE_O = (st_q.hs == gbd_pkg::HS_READY) &
                  participate;
  end

  // Service request only ever driven by us, never ATN, IFC or REN
  assign SRQ_N_O    = 1'b0;
  assign SRQ_N_OE_O = st_q.srq;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d          = st_q;
    st_d.clr      = 1'b0;
    st_d.trig     = 1'b0;
    st_d.data_vld = 1'b0;
    st_d.ren_prev = bus.ren;

    // Handshake sequencing
    case (st_q.hs)
      gbd_pkg::HS_READY:
      begin
        if (capture)
          st_d.hs = gbd_pkg::HS_DONE;
      end
      gbd_pkg::HS_DONE:
      begin
        // Source drops DAV before the next byte
        if (!bus.dav)
          st_d.hs = gbd_pkg::HS_READY;
      end
      default:
        st_d.hs = gbd_pkg::HS_READY;
    endcase

    // Command byte, acted on in the accepting cycle
    if (capture && bus.atn)
    begin
      if (code == gbd_pkg::CMD_UNL)
        st_d.listen = 1'b0;
      else if (code == gbd_pkg::CMD_UNT)
        st_d.talk = 1'b0;
      else if (code == my_lad)
      begin
        st_d.listen = 1'b1;
        if (bus.ren)
          st_d.remote = 1'b1;
      end
      else if (code == my_tad)
        st_d.talk = 1'b1;
      else if (code[6:5] == gbd_pkg::GRP_TALK)
        st_d.talk = 1'b0;    // Another talker takes the bus
      else if (code >= gbd_pkg::SEC_BASE)
        st_d.talk = st_q.talk;  // No secondary addressing
      else if (code == gbd_pkg::CMD_LLO)
        st_d.lockout = 1'b1;
      else if (code == gbd_pkg::CMD_DCL)
        st_d.clr = 1'b1;
      else if (code == gbd_pkg::CMD_SPE)
        st_d.spoll = 1'b1;
      else if (code == gbd_pkg::CMD_SPD)
        st_d.spoll = 1'b0;
      else if (code == gbd_pkg::CMD_SDC && st_q.listen)
        st_d.clr = 1'b1;
      else if (code == gbd_pkg::CMD_GTL && st_q.listen)
      begin
        st_d.remote = 1'b0;
        if (GTL_UNLOCK_I)
          st_d.lockout = 1'b0;
      end
      else if (code == gbd_pkg::CMD_GET &&
               (st_q.listen || GET_ANY_I))
        st_d.trig = 1'b1;
      else
        st_d.talk = st_q.talk;  // Unknown byte: no effect
    end

    // Data byte to the parser, end mark kept with it
    if (capture && !bus.atn)
    begin
      st_d.data     = bus.dio;
      st_d.data_eoi = bus.eoi;
      st_d.data_vld = 1'b1;
    end

    // Panel local button, refused while locked out
    if (LOCAL_BTN_I && !st_q.lockout)
      st_d.remote = 1'b0;

    // Remote follows REN assertion; release of REN clears remote and lockout
    if (bus.ren && !st_q.ren_prev)
      st_d.remote = 1'b1;
    if (!bus.ren)
    begin
      st_d.remote  = 1'b0;
      st_d.lockout = 1'b0;
    end

    // Controller reading status in a poll counts as serviced;
    // a new request in the same cycle still wins
    if (st_q.spoll && st_q.talk)
      st_d.srq = 1'b0;
    if (SERVICE_REQ_I)
      st_d.srq = 1'b1;

    // Interface clear dominates addressing
    if (bus.ifc)
    begin
      st_d.listen = 1'b0;
      st_d.talk   = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      st_q <= gbd_pkg::ST_RESET;
    else
      st_q <= st_d;
  end

  // Outputs straight from the state flops; panel lock also uses REN_LOCKS_PANEL_I
  assign DD_DATA_O    = st_q.data;
  assign DD_EOI_O     = st_q.data_eoi;
  assign DD_VALID_O   = st_q.data_vld;
  assign DEV_CLEAR_O  = st_q.clr;
  assign TRIGGER_O    = st_q.trig;
  assign LISTEN_O     = st_q.listen;
  assign TALK_O       = st_q.talk;
  assign REMOTE_O     = st_q.remote;
  assign LOCKOUT_O    = st_q.lockout;
  assign SPOLL_O      = st_q.spoll;
  // Local button is left usable by REN-only locking
  assign PANEL_LOCK_O = st_q.lockout |
                        (st_q.remote & REN_LOCKS_PANEL_I);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  logic cmd_take;
  assign cmd_take = capture & bus.atn & ~bus.ifc;

  ifc_idle_a: assert property (bus.ifc |=> !LISTEN_O && !TALK_O)
    else $error("IFC left device addressed");

  listen_addr_a: assert property (
    cmd_take && code == my_lad && code != gbd_pkg::CMD_UNL
    |=> LISTEN_O && NRFD_N_OE_O)
    else $error("Own listen address not taken");

  talk_addr_a: assert property (
    cmd_take && code == my_tad && code != gbd_pkg::CMD_UNT |=> TALK_O)
    else $error("Own talk address not taken");

  unlisten_a: assert property (
    capture && bus.atn && code == gbd_pkg::CMD_UNL |=> !LISTEN_O)
    else $error("Unlisten ignored");

  untalk_a: assert property (
    capture && bus.atn && code == gbd_pkg::CMD_UNT |=> !TALK_O)
    else $error("Untalk ignored");

  lockout_set_a: assert property (
    cmd_take && code == gbd_pkg::CMD_LLO && bus.ren
    |=> LOCKOUT_O && PANEL_LOCK_O)
    else $error("Local lockout not set");

  serial_poll_a: assert property (
    cmd_take && code == gbd_pkg::CMD_SPE |=> SPOLL_O [*2])
    else $error("Serial poll mode not entered");

  spoll_off_a: assert property (
    cmd_take && code == gbd_pkg::CMD_SPD |=> !SPOLL_O)
    else $error("Serial poll mode not left");

  dcl_pulse_a: assert property (
    cmd_take && code == gbd_pkg::CMD_DCL |=> DEV_CLEAR_O ##1 !DEV_CLEAR_O)
    else $error("Device clear pulse wrong");

  sdc_gate_a: assert property (
    cmd_take && code == gbd_pkg::CMD_SDC && !LISTEN_O |=> !DEV_CLEAR_O)
    else $error("Selective clear obeyed unaddressed");

  secondary_a: assert property (
    cmd_take && code >= gbd_pkg::SEC_BASE && code != gbd_pkg::CMD_UNT
    |=> $stable(LISTEN_O) && $stable(TALK_O))
    else $error("Secondary byte changed addressing");

  data_fwd_a: assert property (
    capture && !bus.atn
    |=> DD_VALID_O && DD_DATA_O == $past(bus.dio) && !DEV_CLEAR_O)
    else $error("Data byte not forwarded");

  ren_off_a: assert property (
    !bus.ren |=> !REMOTE_O && !LOCKOUT_O)
    else $error("Remote held without REN");

  ren_on_a: assert property (
    bus.ren && !st_q.ren_prev |=> REMOTE_O)
    else $error("REN did not enter remote");

  srq_hold_a: assert property (
    SERVICE_REQ_I |=> SRQ_N_OE_O)
    else $error("Service request not raised");

  // Pending request may only drop once the poll has read us
  srq_keep_a: assert property (
    SRQ_N_OE_O && !(SPOLL_O && TALK_O) |=> SRQ_N_OE_O)
    else $error("Service request dropped early");

  sdc_clear_a: assert property (
    cmd_take && code == gbd_pkg::CMD_SDC && LISTEN_O
    |=> DEV_CLEAR_O ##1 !DEV_CLEAR_O)
    else $error("Selective clear not obeyed");

  // REN already standing, so no assertion edge can re-enter remote
  go_local_a: assert property (
    cmd_take && code == gbd_pkg::CMD_GTL && LISTEN_O && st_q.ren_prev
    |=> !REMOTE_O)
    else $error("Go to local ignored");

  trigger_a: assert property (
    cmd_take && code == gbd_pkg::CMD_GET && (LISTEN_O || GET_ANY_I)
    |=> TRIGGER_O ##1 !TRIGGER_O)
    else $error("Group trigger not obeyed");

  // Data for other listeners must leave both acceptor lines alone
  data_refuse_a: assert property (
    st_q.hs == gbd_pkg::HS_READY && !bus.atn && !LISTEN_O
    |-> !NRFD_N_OE_O && !NDAC_N_OE_O)
    else $error("Handshake on data while not listening");

  hs_done_a: assert property (
    capture |=> NRFD_N_OE_O && !NDAC_N_OE_O ##0 $past(bus.dav))
    else $error("Acceptor handshake out of order");

  // Main scenarios reached
  addr_data_c: cover property (
    cmd_take && code == my_lad ##[1:50] DD_VALID_O);
  poll_c: cover property (SPOLL_O && TALK_O && SRQ_N_OE_O);
  trig_c: cover property (TRIGGER_O);
  ifc_c: cover property (LISTEN_O ##1 bus.ifc);
  lock_c: cover property (LOCKOUT_O && PANEL_LOCK_O && REMOTE_O);

endmodule

// ==== testbench/gbd_ctl_model.sv ====
// Bus controller model: sources command and data bytes, drives the
// management lines and resolves the open-drain acceptor lines.
// Assumes a single device on the bus and pull-ups on every line.
`timescale 1ns/1ps

module gbd_ctl_model
(
  // Clock
  input  wire logic       clk,
  // Device open-drain drives
  input  wire logic       nrfd_i,
  input  wire logic       nrfd_oe_i,
  input  wire logic       ndac_i,
  input  wire logic       ndac_oe_i,
  input  wire logic       srq_i,
  input  wire logic       srq_oe_i,
  // Controller lines, low-true
  output logic            atn_n_o = 1'b1,
  output logic            ifc_n_o = 1'b1,
  output logic            ren_n_o = 1'b1,
  output logic            eoi_n_o = 1'b1,
  output logic            dav_n_o = 1'b1,
  output logic [7:0]      dio_n_o = 8'hFF,
  // Resolved wires
  output wire logic       nrfd_n_o,
  output wire logic       ndac_n_o,
  output wire logic       srq_n_o
);
  // ---------------------------------------------------------------
  // Wired lines
  // ---------------------------------------------------------------
  // Pull-up wins when nobody pulls low
  assign nrfd_n_o = nrfd_oe_i ? nrfd_i : 1'b1;
  assign ndac_n_o = ndac_oe_i ? ndac_i : 1'b1;
  assign srq_n_o  = srq_oe_i ? srq_i : 1'b1;

  // One byte; ok stays low when no acceptor answers in time
  task automatic send(input logic atn, input logic [7:0] b,
                      input logic eoi, output logic ok);
    int t;
    ok = 1'b0;
    atn_n_o = ~atn;
    eoi_n_o = ~eoi;
    dio_n_o = ~b;
    t = 0;
    do
    begin
      @(posedge clk);
      #1;
      t++;
    end while (!(nrfd_n_o === 1'b1 && ndac_n_o === 1'b0) && t < 20);
    // Both lines high means nobody listens: a real source stops here
    if (nrfd_n_o === 1'b1 && ndac_n_o === 1'b0)
    begin
      dav_n_o = 1'b0;
      t = 0;
      do
      begin
        @(posedge clk);
        #1;
        t++;
      end while (ndac_n_o !== 1'b1 && t < 20);
      ok = (ndac_n_o === 1'b1);
    end
    dav_n_o = 1'b1;
    eoi_n_o = 1'b1;
    dio_n_o = 8'hFF;
    @(posedge clk);
    #1;
  endtask

  // Remote enable level
  task automatic ren(input logic v);
    ren_n_o = ~v;
  endtask

  // Interface clear, a few cycles wide
  task automatic ifc();
    ifc_n_o = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    ifc_n_o = 1'b1;
  endtask
endmodule

// ==== testbench/gbd_decoder_tb.sv ====
// Self-checking bench for the instrument bus decoder.
// Assumes the controller model sources every bus byte.
`timescale 1ns/1ps

module gbd_decoder_tb;
  // ---------------------------------------------------------------
  // Stimulus, wires and counters
  // ---------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [4:0] addr = 5'h05;
  logic       ren_lock = 1'b0;
  logic       gtl_unl = 1'b0;
  logic       get_any = 1'b0;
  logic       svc = 1'b0;
  logic       btn = 1'b0;
  logic       ddr = 1'b1;
  logic       atn_n, ifc_n, ren_n, eoi_n, dav_n, nrfd_n, nrfd_o;
  logic       nrfd_oe, ndac_n, ndac_o, ndac_oe, srq_n, srq_o, srq_oe;
  logic       dd_eoi, dd_v, clr, trig, lis, tlk, rem, llo, spl, plk;
  logic       ok, le;
  logic [7:0] dio_n, dd_data, ld;
  logic [7:0] n_dd = 8'h00;
  logic [7:0] n_clr = 8'h00;
  logic [7:0] n_trg = 8'h00;
  int         n_mismatch = 0;
  int         cmp_count = 0;

  gbd_decoder i_gbd_decoder (.CLK_SYS_I(clk), .RST_I(rst),
    .ATN_N_I(atn_n), .IFC_N_I(ifc_n), .REN_N_I(ren_n), .EOI_N_I(eoi_n),
    .DAV_N_I(dav_n), .DIO_N_I(dio_n), .NRFD_N_I(nrfd_n),
    .NRFD_N_O(nrfd_o), .NRFD_N_OE_O(nrfd_oe), .NDAC_N_I(ndac_n),
    .NDAC_N_O(ndac_o), .NDAC_N_OE_O(ndac_oe), .SRQ_N_I(srq_n),
    .SRQ_N_O(srq_o), .SRQ_N_OE_O(srq_oe), .ADDR_I(addr),
    .REN_LOCKS_PANEL_I(ren_lock), .GTL_UNLOCK_I(gtl_unl),
    .GET_ANY_I(get_any), .SERVICE_REQ_I(svc), .LOCAL_BTN_I(btn),
    .DD_READY_I(ddr), .DD_DATA_O(dd_data), .DD_EOI_O(dd_eoi),
    .DD_VALID_O(dd_v), .DEV_CLEAR_O(clr), .TRIGGER_O(trig),
    .LISTEN_O(lis), .TALK_O(tlk), .REMOTE_O(rem), .LOCKOUT_O(llo),
    .SPOLL_O(spl), .PANEL_LOCK_O(plk));

  gbd_ctl_model i_gbd_ctl_model (.clk(clk), .nrfd_i(nrfd_o),
    .nrfd_oe_i(nrfd_oe), .ndac_i(ndac_o), .ndac_oe_i(ndac_oe),
    .srq_i(srq_o), .srq_oe_i(srq_oe), .atn_n_o(atn_n), .ifc_n_o(ifc_n),
    .ren_n_o(ren_n), .eoi_n_o(eoi_n), .dav_n_o(dav_n), .dio_n_o(dio_n),
    .nrfd_n_o(nrfd_n), .ndac_n_o(ndac_n), .srq_n_o(srq_n));

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Pulses stand one cycle, so count them at every edge
  always @(posedge clk)
  begin
    if (dd_v === 1'b1)
    begin
      n_dd <= n_dd + 8'h01;
      ld   <= dd_data;
      le   <= dd_eoi;
    end
    if (clr === 1'b1)
      n_clr <= n_clr + 8'h01;
    if (trig === 1'b1)
      n_trg <= n_trg + 8'h01;
  end

  // ---------------------------------------------------------------
  // Helpers and scenarios
  // ---------------------------------------------------------------
  task automatic ck(input logic [31:0] g, input logic [31:0] e,
                    input string m);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Command byte with attention true; every one must be handshaken
  task automatic cm(input logic [7:0] b);
    i_gbd_ctl_model.send(1'b1, b, 1'b0, ok);
    ck(ok, 1'b1, "cmd not taken");
  endtask

  task automatic t_addr();
    logic [4:0] al [3];
    al = '{5'h00, 5'h10, 5'h1E};
    foreach (al[i])
    begin
      addr = al[i];
      cm({3'h1, al[i] ^ 5'h01});
      ck(lis, 1'b0, "foreign listen");
      cm({3'h1, al[i]});
      ck(lis, 1'b1, "listen addr");
      cm({3'h2, al[i]});
      ck(tlk, 1'b1, "talk addr");
      cm(gbd_pkg::CMD_UNL);
      ck(lis, 1'b0, "unlisten");
      cm(gbd_pkg::CMD_UNT);
      ck(tlk, 1'b0, "untalk");
    end
    addr = 5'h05;
  endtask

  task automatic t_data();
    logic [7:0] n0;
    n0 = n_dd;
    cm(8'h25);
    i_gbd_ctl_model.send(1'b0, 8'h41, 1'b0, ok);
    i_gbd_ctl_model.send(1'b0, 8'h42, 1'b1, ok);
    ck(n_dd, n0 + 8'h02, "data count");
    ck({le, ld}, 9'h142, "last with end");
    ddr = 1'b0;
    fork
      i_gbd_ctl_model.send(1'b0, 8'h3F, 1'b0, ok);
      begin
        cyc(6);
        ck(nrfd_oe, 1'b1, "stall nrfd");
        ck(n_dd, n0 + 8'h02, "stall taken");
        ddr = 1'b1;
      end
    join
    ck({lis, le, ld}, 10'h23F, "data as cmd");
    cm(gbd_pkg::CMD_UNL);
    i_gbd_ctl_model.send(1'b0, 8'h44, 1'b0, ok);
    ck({ok, n_dd}, {1'b0, n0 + 8'h03}, "unlistened data");
  endtask

  task automatic t_ignore();
    logic [7:0] c0;
    logic [7:0] g0;
    c0 = n_clr;
    g0 = n_trg;
    cm(8'h25);
    cm(8'h45);
    cm(8'h60);
    cm(8'h65);
    cm(8'h7E);
    cm(8'h05);
    ck({lis, tlk, rem, llo, spl}, 5'h18, "secondary state");
    ck({n_clr, n_trg}, {c0, g0}, "unknown pulses");
    cm(gbd_pkg::CMD_UNL);
    cm(gbd_pkg::CMD_UNT);
  endtask

  task automatic t_univ();
    logic [7:0] c0;
    c0 = n_clr;
    i_gbd_ctl_model.ren(1'b1);
    cm(gbd_pkg::CMD_LLO);
    ck(llo, 1'b1, "lockout");
    cm(gbd_pkg::CMD_DCL);
    ck(n_clr, c0 + 8'h01, "device clear");
    cm(gbd_pkg::CMD_SPE);
    ck(spl, 1'b1, "poll on");
    cm(gbd_pkg::CMD_SPD);
    ck(spl, 1'b0, "poll off");
    i_gbd_ctl_model.ren(1'b0);
    cyc(2);
    ck({rem, llo}, 2'h0, "ren off");
  endtask

  task automatic t_acmd();
    logic [7:0] c0;
    logic [7:0] g0;
    c0 = n_clr;
    g0 = n_trg;
    ren_lock = 1'b1;
    i_gbd_ctl_model.ren(1'b1);
    cyc(1);
    ck({rem, plk}, 2'h3, "remote");
    cm({1'b0, gbd_pkg::CMD_SDC});
    cm({1'b0, gbd_pkg::CMD_GTL});
    cm({1'b0, gbd_pkg::CMD_GET});
    ck({rem, n_clr, n_trg}, {1'b1, c0, g0}, "unaddressed");
    get_any = 1'b1;
    cm({1'b0, gbd_pkg::CMD_GET});
    ck(n_trg, g0 + 8'h01, "trigger any");
    get_any = 1'b0;
    cm(8'h25);
    cm({1'b0, gbd_pkg::CMD_SDC});
    ck(n_clr, c0 + 8'h01, "selective clear");
    cm({1'b0, gbd_pkg::CMD_GET});
    ck(n_trg, g0 + 8'h02, "trigger");
    cm({1'b0, gbd_pkg::CMD_LLO});
    btn = 1'b1;
    cyc(2);
    ck({rem, llo}, 2'h3, "button locked out");
    btn = 1'b0;
    gtl_unl = 1'b1;
    cm({1'b0, gbd_pkg::CMD_GTL});
    ck({rem, llo, plk}, 3'h0, "go local");
    cm(8'h25);
    ck(rem, 1'b1, "listen remote");
    btn = 1'b1;
    cyc(2);
    ck(rem, 1'b0, "local button");
    btn = 1'b0;
    gtl_unl = 1'b0;
    ren_lock = 1'b0;
    i_gbd_ctl_model.ren(1'b0);
    i_gbd_ctl_model.ifc();
    ck({lis, tlk}, 2'h0, "ifc");
  endtask

  task automatic t_srq();
    svc = 1'b1;
    cyc(1);
    svc = 1'b0;
    cyc(8);
    ck({srq_oe, srq_n}, 2'h2, "srq held");
    cm(gbd_pkg::CMD_SPE);
    ck(srq_oe, 1'b1, "srq at poll");
    cm(8'h45);
    ck(srq_oe, 1'b0, "srq served");
    cm(gbd_pkg::CMD_SPD);
    cm(gbd_pkg::CMD_UNT);
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after twelve cycles of reset
  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(1);
    ck({lis, tlk, rem, llo, spl, srq_oe, dd_v, clr}, 8'h00, "reset");
    t_addr();
    t_data();
    t_ignore();
    t_univ();
    t_acmd();
    t_srq();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
